// *** shared/isbs_defines.vh ***
// register map, field positions and constants of the slave buffer status block
`ifndef ISBS_DEFINES_VH
`define ISBS_DEFINES_VH

`define ISBS_PAW 8
`define ISBS_OFS_CTRL 8'h00
`define ISBS_OFS_CMD 8'h04
`define ISBS_OFS_WR_SIZE 8'h08
`define ISBS_OFS_RD_SIZE 8'h0C
`define ISBS_OFS_WR_COUNT 8'h10
`define ISBS_OFS_RD_COUNT 8'h14
`define ISBS_OFS_STATUS 8'h18
`define ISBS_OFS_WR_BASE 8'h1C
`define ISBS_OFS_RD_BASE 8'h20

`define ISBS_CTRL_EN 0
`define ISBS_CTRL_IRQ_EN 1
`define ISBS_CTRL_BOOT 2
`define ISBS_CTRL_W 3
`define ISBS_CTRL_RST 3'h0

`define ISBS_CMD_CLR_WR_IDX 0
`define ISBS_CMD_CLR_RD_IDX 1
`define ISBS_CMD_CLR_WR_ST 2
`define ISBS_CMD_CLR_RD_ST 3
`define ISBS_CMD_COMM_RESET 4
`define ISBS_CMD_COMM_STOP 5
`define ISBS_CMD_COMM_START 6
`define ISBS_CMD_RESP_READY 7

`define ISBS_ST_RD_DONE 0
`define ISBS_ST_RD_ACT 1
`define ISBS_ST_RD_OVR 2
`define ISBS_ST_WR_DONE 4
`define ISBS_ST_WR_ACT 5
`define ISBS_ST_WR_OVR 6
`define ISBS_ST_W 7
`define ISBS_ST_RST 7'h00

`define ISBS_FILLER 8'hFF
`define ISBS_SIZE_RST 8'h00

`endif

// *** hdl/isbs_fifo.v ***
// small synchronous fifo with a registered output stage
`timescale 1ns/100ps
module isbs_fifo #(
	parameter W = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk, // clock
	input wire rst_n, // async reset, active low
	input wire in_valid, // write request
	output wire in_ready, // room for one more word
	input wire [W-1:0] in_data, // write data
	output reg out_valid_r, // output register holds a word
	input wire out_ready, // sink takes the word
	output reg [W-1:0] out_data_r // registered read data
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_r;
	reg [AW-1:0] rptr_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	wire load;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign push = in_valid & in_ready;
	// refill the output register whenever a word is stored and the register is empty or being taken
	assign load = (cnt_r != {(AW+1){1'b0}}) & (~out_valid_r | out_ready);
	assign pop = load;

	always @(posedge clk) begin
		if (push) begin
			mem[wptr_r] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= {AW{1'b0}};
			rptr_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			out_valid_r <= 1'b0;
			out_data_r <= {W{1'b0}};
		end else begin
			if (push) begin
				wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_r + 1'b1;
				out_data_r <= mem[rptr_r];
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - 1'b1;
			end
			if (load) begin
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end
endmodule // isbs_fifo

// *** hdl/isbs_core.v ***
// slave buffer indexes, status flags and boot command mode behind an apb slave
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "isbs_defines.vh"

module isbs_core #(
	parameter AW = 8,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire pclk, // apb clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [`ISBS_PAW-1:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata_r, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped address
	input wire lnk_start, // bus engine: transaction addressed to us begins
	input wire lnk_dir, // direction of that transaction, 1 = master reads
	input wire lnk_stop, // bus engine: transaction ends
	input wire lnk_wr_valid, // byte written by the master
	input wire [7:0] lnk_wr_data, // that byte
	output wire lnk_wr_ready, // byte taken, low stretches the bus
	output reg lnk_ack_valid_r, // ack decision valid
	output reg lnk_ack_r, // 1 = ack, 0 = nack
	input wire lnk_rd_req, // master wants the next byte
	output reg lnk_rd_valid_r, // read byte valid
	output reg [7:0] lnk_rd_data_r, // read byte
	output reg rmem_en_r, // read buffer fetch
	output reg [AW-1:0] rmem_addr_r, // read buffer address
	input wire [7:0] rmem_data, // read buffer data, in the cycle of the fetch
	output wire wmem_valid, // write buffer store request
	input wire wmem_ready, // store accepted
	output wire [AW-1:0] wmem_addr, // write buffer address
	output wire [7:0] wmem_data, // write buffer data
	output wire blk_en, // block enabled
	output wire blk_irq_en // bus engine interrupt enabled
);
	reg [`ISBS_CTRL_W-1:0] ctrl_r;
	reg [AW-1:0] wr_size_r;
	reg [AW-1:0] rd_size_r;
	reg [AW-1:0] wr_base_r;
	reg [AW-1:0] rd_base_r;
	reg [AW-1:0] wr_cnt_r;
	reg [AW-1:0] rd_cnt_r;
	reg [`ISBS_ST_W-1:0] st_r;
	reg [`ISBS_ST_W-1:0] st_nxt;
	reg act_r;
	reg act_dir_r;
	reg resp_ready_r;
	reg fill_r;

	wire apb_wr;
	wire [7:0] cmd;
	wire en;
	wire boot;
	wire wr_room;
	wire rd_room;
	wire wr_acc;
	wire push;
	wire fifo_in_ready;
	wire rd_take;
	wire rd_filler;
	wire boot_wr_start;
	wire [AW:0] wsum;
	wire [AW:0] rsum;
	wire [2*AW-1:0] fifo_out;

	function hit;
		input [`ISBS_PAW-1:0] a;
		begin
			case (a)
				`ISBS_OFS_CTRL, `ISBS_OFS_CMD, `ISBS_OFS_WR_SIZE, `ISBS_OFS_RD_SIZE,
				`ISBS_OFS_WR_COUNT, `ISBS_OFS_RD_COUNT, `ISBS_OFS_STATUS,
				`ISBS_OFS_WR_BASE, `ISBS_OFS_RD_BASE: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
	endfunction

	function is_reg;
		input [`ISBS_PAW-1:0] a;
		input [`ISBS_PAW-1:0] ofs;
		begin
			is_reg = apb_wr & (a == ofs);
		end
	endfunction

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit(paddr);
	assign apb_wr = psel & penable & pwrite;
	assign cmd = is_reg(paddr, `ISBS_OFS_CMD) ? pwdata[7:0] : 8'h00;
	assign en = ctrl_r[`ISBS_CTRL_EN];
	assign boot = ctrl_r[`ISBS_CTRL_BOOT];
	assign blk_en = en;
	assign blk_irq_en = ctrl_r[`ISBS_CTRL_IRQ_EN];

	// registered read data, loaded in the setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_r <= 32'h0000_0000;
			case (paddr)
				`ISBS_OFS_CTRL: prdata_r[`ISBS_CTRL_W-1:0] <= ctrl_r;
				`ISBS_OFS_WR_SIZE: prdata_r[AW-1:0] <= wr_size_r;
				`ISBS_OFS_RD_SIZE: prdata_r[AW-1:0] <= rd_size_r;
				`ISBS_OFS_WR_COUNT: prdata_r[AW-1:0] <= wr_cnt_r;
				`ISBS_OFS_RD_COUNT: prdata_r[AW-1:0] <= rd_cnt_r;
				`ISBS_OFS_STATUS: prdata_r[`ISBS_ST_W-1:0] <= st_r;
				`ISBS_OFS_WR_BASE: prdata_r[AW-1:0] <= wr_base_r;
				`ISBS_OFS_RD_BASE: prdata_r[AW-1:0] <= rd_base_r;
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// control bits, sizes and bases
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `ISBS_CTRL_RST;
			wr_size_r <= `ISBS_SIZE_RST;
			rd_size_r <= `ISBS_SIZE_RST;
			wr_base_r <= `ISBS_SIZE_RST;
			rd_base_r <= `ISBS_SIZE_RST;
		end else begin
			if (is_reg(paddr, `ISBS_OFS_CTRL)) begin
				ctrl_r <= pwdata[`ISBS_CTRL_W-1:0];
			end
			if (cmd[`ISBS_CMD_COMM_START]) begin
				ctrl_r[`ISBS_CTRL_EN] <= 1'b1;
				ctrl_r[`ISBS_CTRL_IRQ_EN] <= 1'b1;
			end
			if (cmd[`ISBS_CMD_COMM_STOP]) begin
				ctrl_r[`ISBS_CTRL_EN] <= 1'b0;
				ctrl_r[`ISBS_CTRL_IRQ_EN] <= 1'b0;
			end
			if (is_reg(paddr, `ISBS_OFS_WR_SIZE)) begin
				wr_size_r <= pwdata[AW-1:0];
			end
			if (is_reg(paddr, `ISBS_OFS_RD_SIZE)) begin
				rd_size_r <= pwdata[AW-1:0];
			end
			if (is_reg(paddr, `ISBS_OFS_WR_BASE)) begin
				wr_base_r <= pwdata[AW-1:0];
			end
			if (is_reg(paddr, `ISBS_OFS_RD_BASE)) begin
				rd_base_r <= pwdata[AW-1:0];
			end
		end
	end

	// write direction: separate index into its own buffer
	assign wr_room = (wr_cnt_r < wr_size_r);
	assign lnk_wr_ready = ~en | ~wr_room | fifo_in_ready;
	assign wr_acc = lnk_wr_valid & lnk_wr_ready;
	assign push = wr_acc & en & wr_room;
	assign boot_wr_start = lnk_start & ~lnk_dir & boot & en;
	assign wsum = {1'b0, wr_base_r} + {1'b0, wr_cnt_r};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt_r <= {AW{1'b0}};
			lnk_ack_valid_r <= 1'b0;
			lnk_ack_r <= 1'b0;
		end else begin
			lnk_ack_valid_r <= wr_acc;
			lnk_ack_r <= push;
			if (is_reg(paddr, `ISBS_OFS_WR_SIZE) | is_reg(paddr, `ISBS_OFS_WR_BASE)) begin
				wr_cnt_r <= {AW{1'b0}};
			end else if (cmd[`ISBS_CMD_CLR_WR_IDX] | cmd[`ISBS_CMD_COMM_RESET]) begin
				wr_cnt_r <= {AW{1'b0}};
			end else if (boot_wr_start) begin
				wr_cnt_r <= {AW{1'b0}};
			end else if (push) begin
				wr_cnt_r <= wr_cnt_r + 1'b1;
			end
		end
	end

	isbs_fifo #(
		.W(2*AW),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_wfifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({wsum[AW-1:0], lnk_wr_data}),
		.out_valid_r(wmem_valid),
		.out_ready(wmem_ready),
		.out_data_r(fifo_out)
	);
	assign wmem_addr = fifo_out[2*AW-1:8];
	assign wmem_data = fifo_out[7:0];

	// read direction
	assign rd_room = (rd_cnt_r < rd_size_r);
	assign rd_filler = ~en | ~rd_room | (boot & ~resp_ready_r);
	assign rd_take = lnk_rd_req & ~rd_filler;
	assign rsum = {1'b0, rd_base_r} + {1'b0, rd_cnt_r};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cnt_r <= {AW{1'b0}};
			rmem_en_r <= 1'b0;
			rmem_addr_r <= {AW{1'b0}};
			fill_r <= 1'b0;
			lnk_rd_valid_r <= 1'b0;
			lnk_rd_data_r <= 8'h00;
			resp_ready_r <= 1'b0;
		end else begin
			rmem_en_r <= rd_take;
			fill_r <= lnk_rd_req & rd_filler;
			if (rd_take) begin
				rmem_addr_r <= rsum[AW-1:0];
			end
			lnk_rd_valid_r <= rmem_en_r | fill_r;
			if (rmem_en_r) begin
				lnk_rd_data_r <= rmem_data;
			end else if (fill_r) begin
				lnk_rd_data_r <= `ISBS_FILLER;
			end
			if (cmd[`ISBS_CMD_RESP_READY]) begin
				resp_ready_r <= 1'b1;
			end else if (boot_wr_start | cmd[`ISBS_CMD_COMM_RESET]) begin
				resp_ready_r <= 1'b0;
			end
			if (is_reg(paddr, `ISBS_OFS_RD_SIZE) | is_reg(paddr, `ISBS_OFS_RD_BASE)) begin
				rd_cnt_r <= {AW{1'b0}};
			end else if (cmd[`ISBS_CMD_CLR_RD_IDX] | cmd[`ISBS_CMD_COMM_RESET]) begin
				rd_cnt_r <= {AW{1'b0}};
			end else if (cmd[`ISBS_CMD_RESP_READY]) begin
				rd_cnt_r <= {AW{1'b0}};
			end else if (rd_take) begin
				rd_cnt_r <= rd_cnt_r + 1'b1;
			end
		end
	end

	// status flags: clears first, hardware events last so a set wins
	always @* begin
		st_nxt = st_r;
		if (cmd[`ISBS_CMD_COMM_RESET]) begin
			st_nxt = `ISBS_ST_RST;
		end
		if (cmd[`ISBS_CMD_CLR_RD_ST]) begin
			st_nxt[`ISBS_ST_RD_DONE] = 1'b0;
			st_nxt[`ISBS_ST_RD_OVR] = 1'b0;
		end
		if (cmd[`ISBS_CMD_CLR_WR_ST]) begin
			st_nxt[`ISBS_ST_WR_DONE] = 1'b0;
			st_nxt[`ISBS_ST_WR_OVR] = 1'b0;
		end
		// a stop or a restart completes the running transfer
		if (act_r & (lnk_stop | lnk_start)) begin
			if (act_dir_r) begin
				st_nxt[`ISBS_ST_RD_ACT] = 1'b0;
				st_nxt[`ISBS_ST_RD_DONE] = 1'b1;
			end else begin
				st_nxt[`ISBS_ST_WR_ACT] = 1'b0;
				st_nxt[`ISBS_ST_WR_DONE] = 1'b1;
			end
		end
		if (lnk_start & en) begin
			if (lnk_dir) begin
				st_nxt[`ISBS_ST_RD_ACT] = 1'b1;
			end else begin
				st_nxt[`ISBS_ST_WR_ACT] = 1'b1;
			end
		end
		if (wr_acc & en & ~wr_room) begin
			st_nxt[`ISBS_ST_WR_OVR] = 1'b1;
		end
		if (lnk_rd_req & en & ~rd_room) begin
			st_nxt[`ISBS_ST_RD_OVR] = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= `ISBS_ST_RST;
			act_r <= 1'b0;
			act_dir_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (lnk_start & en) begin
				act_r <= 1'b1;
				act_dir_r <= lnk_dir;
			end else if (lnk_stop | cmd[`ISBS_CMD_COMM_RESET]) begin
				act_r <= 1'b0;
			end
		end
	end
endmodule // isbs_core

// *** bench/isbs_core_properties.sv ***
// port assertions for the slave buffer status block
`timescale 1ns/100ps
`include "isbs_defines.vh"
module isbs_core_properties #(
	parameter AW = 8
) (
	input wire pclk, // clock
	input wire presetn, // reset
	input wire psel, // apb
	input wire penable, // apb
	input wire pwrite, // apb
	input wire [`ISBS_PAW-1:0] paddr, // apb
	input wire [31:0] pwdata, // apb
	input wire pslverr, // apb
	input wire lnk_wr_valid, // link
	input wire lnk_wr_ready, // link
	input wire lnk_ack_valid_r, // link
	input wire lnk_ack_r, // link
	input wire lnk_rd_req, // link
	input wire lnk_rd_valid_r, // link
	input wire [7:0] lnk_rd_data_r, // link
	input wire wmem_valid, // store
	input wire wmem_ready, // store
	input wire [AW-1:0] wmem_addr, // store
	input wire [7:0] wmem_data, // store
	input wire blk_en, // enable
	input wire blk_irq_en // irq enable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire cmd_wr = psel && penable && pwrite && paddr == `ISBS_OFS_CMD;
	AST_ACK_CAUSE: assert property (lnk_ack_valid_r |-> $past(lnk_wr_valid && lnk_wr_ready))
		else $error("ack without an accepted byte");
	AST_ACK_OFF: assert property ((lnk_wr_valid && lnk_wr_ready && !blk_en) |=>
		lnk_ack_valid_r && !lnk_ack_r) else $error("byte acked while disabled");
	AST_RD_LAT: assert property (lnk_rd_req |-> ##2 lnk_rd_valid_r)
		else $error("read byte late");
	AST_RD_CAUSE: assert property (lnk_rd_valid_r |-> $past(lnk_rd_req, 2))
		else $error("read byte without request");
	AST_RD_OFF: assert property ((lnk_rd_req && !blk_en) |-> ##2 lnk_rd_data_r == `ISBS_FILLER)
		else $error("no filler while disabled");
	AST_WMEM_HOLD: assert property (wmem_valid && !wmem_ready |=>
		wmem_valid && $stable(wmem_addr) && $stable(wmem_data)) else $error("store dropped");
	AST_STOP: assert property (cmd_wr && pwdata[5] |=> !blk_en && !blk_irq_en)
		else $error("stop left block on");
	AST_START: assert property (cmd_wr && pwdata[6] && !pwdata[5] |=> blk_en && blk_irq_en)
		else $error("start left block off");
	AST_ERR: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	cover property (lnk_ack_valid_r && !lnk_ack_r);
	cover property (lnk_rd_valid_r && lnk_rd_data_r == `ISBS_FILLER);
	cover property (wmem_valid && !wmem_ready);
endmodule // isbs_core_properties
bind isbs_core isbs_core_properties #(.AW(AW)) isbs_core_properties_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .lnk_wr_valid, .lnk_wr_ready,
	.lnk_ack_valid_r, .lnk_ack_r, .lnk_rd_req, .lnk_rd_valid_r, .lnk_rd_data_r, .wmem_valid,
	.wmem_ready, .wmem_addr, .wmem_data, .blk_en, .blk_irq_en);

// *** bench/isbs_far_mem.sv ***
// far side model: read buffer memory and a write buffer sink that stalls
`timescale 1ns/100ps
module isbs_far_mem (
	input wire pclk, // clock
	input wire presetn, // reset
	input wire rmem_en_r, // fetch
	input wire [7:0] rmem_addr_r, // fetch address
	output wire [7:0] rmem_data, // fetched byte
	input wire wmem_valid, // store request
	output wire wmem_ready, // store taken
	input wire [7:0] wmem_addr, // store address
	input wire [7:0] wmem_data // store byte
);
	reg [7:0] mem [0:255];
	reg [2:0] cnt_r;
	integer i;
	initial for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
	// stall two cycles of eight
	assign wmem_ready = cnt_r[2:1] != 2'h3;
	// the core latches the byte while its fetch strobe stands, so the read is combinational
	// between fetches the data does not hold
	assign rmem_data = rmem_en_r ? mem[rmem_addr_r] : ~mem[rmem_addr_r];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			if (wmem_valid && wmem_ready)
				mem[wmem_addr] <= wmem_data;
		end
	end
endmodule // isbs_far_mem

// *** bench/isbs_core_tb.sv ***
// self-checking bench for the slave buffer status block
`timescale 1ns/100ps
`include "isbs_defines.vh"
module isbs_core_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg [7:0] paddr = 8'h00, lnk_wr_data = 8'h00;
	reg [31:0] pwdata = 32'h0, lf = 95051, rd;
	reg lnk_start = 0, lnk_dir = 0, lnk_stop = 0, lnk_wr_valid = 0, lnk_rd_req = 0, er;
	wire [31:0] prdata_r;
	wire pready, pslverr, lnk_wr_ready, lnk_ack_valid_r, lnk_ack_r, lnk_rd_valid_r;
	wire [7:0] lnk_rd_data_r, rmem_addr_r, rmem_data, wmem_addr, wmem_data;
	wire rmem_en_r, wmem_valid, wmem_ready, blk_en, blk_irq_en;
	integer n_fail = 0, total_checks = 0, cyc = 0, wcnt = 0, i, t;
	reg [7:0] q[$];
	always #2.5 pclk = ~pclk;
	isbs_core isbs_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_r, .pready, .pslverr, .lnk_start, .lnk_dir, .lnk_stop, .lnk_wr_valid,
		.lnk_wr_data, .lnk_wr_ready, .lnk_ack_valid_r, .lnk_ack_r, .lnk_rd_req, .lnk_rd_valid_r,
		.lnk_rd_data_r, .rmem_en_r, .rmem_addr_r, .rmem_data, .wmem_valid, .wmem_ready,
		.wmem_addr, .wmem_data, .blk_en, .blk_irq_en);
	isbs_far_mem isbs_far_mem_inst (.pclk, .presetn, .rmem_en_r, .rmem_addr_r, .rmem_data,
		.wmem_valid, .wmem_ready, .wmem_addr, .wmem_data);
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [31:0] s, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, s, e);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d, mismatches %0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rd = prdata_r;
			er = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		begin
			apb(0, a, 0);
			chk(rd, e);
		end
	endtask
	task ev(input s, input dir);
		begin
			@(posedge pclk);
			// only transactions that match our rate and address reach the core
			lnk_start <= s;
			lnk_stop <= !s;
			lnk_dir <= dir;
			@(posedge pclk);
			lnk_start <= 0;
			lnk_stop <= 0;
		end
	endtask
	// one master byte; the model acks while the count is below size
	task wb(input [7:0] wsz);
		begin
			lf = nx(lf);
			@(posedge pclk);
			lnk_wr_valid <= 1;
			lnk_wr_data <= lf[7:0];
			@(posedge pclk);
			while (lnk_wr_ready !== 1'b1)
				@(posedge pclk);
			lnk_wr_valid <= 0;
			@(posedge pclk);
			chk(lnk_ack_valid_r, 1);
			chk(lnk_ack_r, wcnt < wsz);
			if (wcnt < wsz) begin
				q.push_back(lf[7:0]);
				wcnt = wcnt + 1;
			end
		end
	endtask
	task rb(input [7:0] e);
		begin
			@(posedge pclk);
			lnk_rd_req <= 1;
			@(posedge pclk);
			lnk_rd_req <= 0;
			repeat (2) @(posedge pclk);
			chk(lnk_rd_valid_r, 1);
			chk(lnk_rd_data_r, e);
		end
	endtask
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			test_done;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rchk(`ISBS_OFS_STATUS, 0);
		apb(0, 8'hFC, 0);
		chk(er, 1);
		apb(1, `ISBS_OFS_WR_BASE, 8'h10);
		apb(1, `ISBS_OFS_WR_SIZE, 6);
		apb(1, `ISBS_OFS_RD_BASE, 8'h40);
		apb(1, `ISBS_OFS_RD_SIZE, 3);
		rchk(`ISBS_OFS_WR_COUNT, 0);
		apb(1, `ISBS_OFS_CTRL, 1);
		for (t = 0; t < 2; t = t + 1) begin
			ev(1, 0);
			rchk(`ISBS_OFS_STATUS, t ? 32'h30 : 32'h20);
			for (i = 0; i < 4; i = i + 1)
				wb(6);
			ev(0, 0);
			rchk(`ISBS_OFS_WR_COUNT, wcnt);
		end
		rchk(`ISBS_OFS_STATUS, 32'h50);
		repeat (30) @(posedge pclk);
		for (i = 0; i < 6; i = i + 1)
			chk(isbs_far_mem_inst.mem[8'h10 + i], q[i]);
		apb(1, `ISBS_OFS_CMD, 32'h04);
		rchk(`ISBS_OFS_STATUS, 0);
		apb(1, `ISBS_OFS_CMD, 32'h01);
		rchk(`ISBS_OFS_WR_COUNT, 0);
		wcnt = 0;
		ev(1, 0);
		wb(6);
		ev(0, 0);
		repeat (30) @(posedge pclk);
		chk(isbs_far_mem_inst.mem[8'h10], q[6]);
		ev(1, 1);
		for (i = 0; i < 4; i = i + 1)
			rb(i < 3 ? (8'h40 + i) ^ 8'h5A : 8'hFF);
		ev(0, 1);
		rchk(`ISBS_OFS_STATUS, 32'h15);
		rchk(`ISBS_OFS_RD_COUNT, 3);
		apb(1, `ISBS_OFS_CMD, 32'h08);
		rchk(`ISBS_OFS_STATUS, 32'h10);
		apb(1, `ISBS_OFS_CMD, 32'h02);
		apb(1, `ISBS_OFS_CTRL, 5);
		rb(8'hFF);
		apb(1, `ISBS_OFS_CMD, 32'h80);
		rb(8'h40 ^ 8'h5A);
		apb(1, `ISBS_OFS_CMD, 32'h10);
		rchk(`ISBS_OFS_STATUS, 0);
		rchk(`ISBS_OFS_RD_COUNT, 0);
		apb(1, `ISBS_OFS_CMD, 32'h20);
		@(posedge pclk);
		chk(blk_en | blk_irq_en, 0);
		rb(8'hFF);
		wb(0);
		apb(1, `ISBS_OFS_CMD, 32'h40);
		@(posedge pclk);
		chk(blk_en & blk_irq_en, 1);
		test_done;
	end
endmodule // isbs_core_tb
